/* File: hw/tmr_pkg.sv */
// Purpose: Shared constants for the 8-bit timer/counter with PWM.
// Assumes: Registers are 8 bits wide on a plain byte register port.
// Notes: Addresses are the byte addresses of the register port.
package tmr_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int TMR_DW = 8;
    localparam int TMR_AW = 8;
    localparam int TMR_PRE_BITS = 7;
    localparam int TMR_RATE_W = 3;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [TMR_AW-1:0] TMR_MODE_ADDR = 8'hB4;
    localparam logic [TMR_AW-1:0] TMR_COUNT_ADDR = 8'hB5;
    localparam logic [TMR_AW-1:0] TMR_RELOAD_ADDR = 8'hB6;
    localparam logic [TMR_AW-1:0] TMR_DUTY_ADDR = 8'hB7;
    localparam logic [TMR_AW-1:0] TMR_STAT_ADDR = 8'hB8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_RATE_LSB = 4;
    localparam int MODE_EXT_BIT = 3;
    localparam int MODE_INT_BIT = 2;
    localparam int MODE_PWM_BIT = 0;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_IEN_BIT = 1;

    // ****************************************
    // Reset values and constants
    // ****************************************
    localparam logic [TMR_DW-1:0] TMR_RST_VAL = 8'h00;
    localparam logic [TMR_DW-1:0] MODE_RW_MASK = 8'hFD;
    localparam logic [TMR_DW-1:0] TMR_COUNT_FULL = 8'hFF;
    localparam logic [TMR_DW-1:0] TMR_COUNT_ONE = 8'h01;
    localparam logic [TMR_RATE_W-1:0] TMR_RATE_DIV1 = 3'h7;
    localparam logic [TMR_PRE_BITS-1:0] TMR_PRE_ALL = 7'h7F;

    // Mask of prescaler bits that must all be set for a tick.
    function automatic logic [TMR_PRE_BITS-1:0] tmr_rate_mask(
        input logic [TMR_RATE_W-1:0] code
    );
        tmr_rate_mask = TMR_PRE_ALL >> code;
    endfunction

endpackage

/* File: hw/tmr_prescaler.sv */
// Purpose: Free-running divider giving a one-cycle count tick.
// Assumes: srcTick is a one-cycle enable on the same clock.
// Notes: Code 0 divides by 128, code 7 passes every source tick.
`timescale 1ns/1ps
`default_nettype none
module tmr_prescaler
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic srcTick,
    input wire logic [TMR_RATE_W-1:0] rateSel,
    output logic divTick
);

    logic [TMR_PRE_BITS-1:0] div_r;
    logic [TMR_PRE_BITS-1:0] mask;

    // A tick rather than a derived clock keeps one clock domain.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_r <= '0;
        end else if (srcTick) begin
            div_r <= div_r + 7'h01;
        end
    end

    assign mask = tmr_rate_mask(rateSel);
    assign divTick = srcTick && ((div_r & mask) == mask);

    property p_div1;
        @(posedge clk) disable iff (reset)
        (rateSel == TMR_RATE_DIV1) && srcTick |-> divTick;
    endproperty
    a_div1: assert property (p_div1)
        else $error("divide-by-one code dropped a source tick");

endmodule
`default_nettype wire

/* File: hw/tmr_timer8.sv */
// Purpose: 8-bit up timer/counter with auto-reload and PWM output.
// Assumes: cpuTick and hoscTick are one-cycle enables on clk.
// Notes: The event pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer8
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [TMR_AW-1:0] regAddr,
    input wire logic [TMR_DW-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [TMR_DW-1:0] regRdData,
    input wire logic cpuTick,
    input wire logic hoscTick,
    input wire logic eventPinIn,
    input wire logic gpioOut,
    input wire logic gpioOe,
    output logic pwmPinOut,
    output logic pwmPinOe,
    output logic overflowIrq,
    output logic wakeupReq
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [TMR_DW-1:0] mode_r, count_r, duty_r;
    logic [TMR_DW-1:0] holdReload_r, activeReload_r, reloadNow;
    logic [TMR_DW-1:0] rdData_r, rdData_nxt;
    logic flag_r, ien_r, pwm_r, pwm_nxt, enLast_r;
    logic [1:0] evtSync_r;
    logic evtLast_r, evtFall;
    logic countEn, extSel, intSel, pwmEn;
    logic [TMR_RATE_W-1:0] rateSel;
    logic srcTick, preTick, countTick, ovfEvent, enRise;
    logic modeWrite, countWrite, reloadWrite, dutyWrite, statWrite;
    logic dutyAbove;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ****************************************
    // Register decode
    // ****************************************
    assign modeWrite = regWrite && (regAddr == TMR_MODE_ADDR);
    assign countWrite = regWrite && (regAddr == TMR_COUNT_ADDR);
    assign reloadWrite = regWrite && (regAddr == TMR_RELOAD_ADDR);
    assign dutyWrite = regWrite && (regAddr == TMR_DUTY_ADDR);
    assign statWrite = regWrite && (regAddr == TMR_STAT_ADDR);

    assign countEn = mode_r[MODE_EN_BIT];
    assign extSel = mode_r[MODE_EXT_BIT];
    assign intSel = mode_r[MODE_INT_BIT];
    assign pwmEn = mode_r[MODE_PWM_BIT];
    assign rateSel = mode_r[MODE_RATE_LSB +: TMR_RATE_W];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_r <= TMR_RST_VAL;
        end else if (modeWrite) begin
            mode_r <= regWrData & MODE_RW_MASK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            duty_r <= TMR_RST_VAL;
        end else if (dutyWrite) begin
            duty_r <= regWrData;
        end
    end

    // Software writes land in the holding buffer only.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            holdReload_r <= TMR_RST_VAL;
        end else if (reloadWrite) begin
            holdReload_r <= regWrData;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ien_r <= 1'b0;
        end else if (statWrite) begin
            ien_r <= regWrData[STAT_IEN_BIT];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // The reload register is write-only and reads back as zero.
    always_comb begin
        rdData_nxt = TMR_RST_VAL;
        case (regAddr)
            TMR_MODE_ADDR: begin
                rdData_nxt = mode_r;
            end
            TMR_COUNT_ADDR: begin
                rdData_nxt = count_r;
            end
            TMR_DUTY_ADDR: begin
                rdData_nxt = duty_r;
            end
            TMR_STAT_ADDR: begin
                rdData_nxt[STAT_FLAG_BIT] = flag_r;
                rdData_nxt[STAT_IEN_BIT] = ien_r;
            end
            default: begin
                rdData_nxt = TMR_RST_VAL;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData_r <= TMR_RST_VAL;
        end else if (regRead) begin
            rdData_r <= rdData_nxt;
        end else begin
            rdData_r <= TMR_RST_VAL;
        end
    end

    assign regRdData = rdData_r;

    // ****************************************
    // Event input
    // ****************************************
    // Only the second stage feeds the edge detector.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evtSync_r <= 2'b11;
            evtLast_r <= 1'b1;
        end else begin
            evtSync_r <= {evtSync_r[0], eventPinIn};
            evtLast_r <= evtSync_r[1];
        end
    end

    assign evtFall = evtLast_r && !evtSync_r[1];

    // ****************************************
    // Clock source and prescaler
    // ****************************************
    assign srcTick = intSel ? hoscTick : cpuTick;

    tmr_prescaler u_prescaler (
        .clk(clk),
        .reset(reset),
        .srcTick(srcTick),
        .rateSel(rateSel),
        .divTick(preTick)
    );

    // The prescaler is bypassed entirely in event mode.
    assign countTick = countEn && (extSel ? evtFall : preTick);
    assign ovfEvent = countTick && (count_r == TMR_COUNT_FULL);
    assign enRise = countEn && !enLast_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enLast_r <= 1'b0;
        end else begin
            enLast_r <= countEn;
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    // A software write to the counter takes priority over a tick.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= TMR_RST_VAL;
        end else if (countWrite) begin
            count_r <= regWrData;
        end else if (ovfEvent) begin
            count_r <= holdReload_r;
        end else if (countTick) begin
            count_r <= count_r + TMR_COUNT_ONE;
        end
    end

    // The active copy follows only at overflow or at enable.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            activeReload_r <= TMR_RST_VAL;
        end else if (ovfEvent || enRise) begin
            activeReload_r <= holdReload_r;
        end
    end

    // ****************************************
    // Overflow flag and request
    // ****************************************
    // A new overflow wins over a clear in the same cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_r <= 1'b0;
        end else if (ovfEvent) begin
            flag_r <= 1'b1;
        end else if (statWrite && !regWrData[STAT_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    assign overflowIrq = flag_r && ien_r;

    // Low-power modes change nothing here; no wake source exists.
    assign wakeupReq = 1'b0;

    // ****************************************
    // PWM
    // ****************************************
    // At a reload the new period's compare value already applies.
    assign reloadNow = (ovfEvent || enRise) ? holdReload_r : activeReload_r;
    assign dutyAbove = duty_r > reloadNow;

    always_comb begin
        pwm_nxt = pwm_r;
        if (!countEn || !dutyAbove) begin
            pwm_nxt = 1'b0;
        end else if (ovfEvent || enRise) begin
            pwm_nxt = 1'b1;
        end else if (count_r == duty_r) begin
            pwm_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= pwm_nxt;
        end
    end

    // Clearing the PWM bit hands the pin straight back to the GPIO.
    assign pwmPinOut = pwmEn ? pwm_r : gpioOut;
    assign pwmPinOe = pwmEn ? 1'b1 : gpioOe;

    // ****************************************
    // Assertions
    // ****************************************
    property p_hold;
        !countEn && !countWrite |=> $stable(count_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved while disabled");

    property p_inc;
        countTick && !countWrite && (count_r != TMR_COUNT_FULL)
            |=> count_r == $past(count_r) + TMR_COUNT_ONE;
    endproperty
    a_inc: assert property (p_inc)
        else $error("counter did not step by one");

    property p_ovf_flag;
        ovfEvent |=> flag_r;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow flag not set");

    property p_flag_hold;
        flag_r && !(statWrite && !regWrData[STAT_FLAG_BIT]) |=> flag_r;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("overflow flag dropped without a clear");

    property p_reload;
        ovfEvent && !countWrite |=> count_r == $past(holdReload_r);
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter not reloaded at overflow");

    property p_buffer;
        reloadWrite && !ovfEvent && !enRise
            |=> activeReload_r == $past(activeReload_r);
    endproperty
    a_buffer: assert property (p_buffer)
        else $error("reload write reached active copy early");

    property p_irq;
        ovfEvent && ien_r && !statWrite |=> overflowIrq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled overflow raised no request");

    property p_wake;
        ovfEvent |-> !wakeupReq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("timer raised a wake request");

    property p_ext;
        countEn && extSel && !evtFall && !countWrite |=> $stable(count_r);
    endproperty
    a_ext: assert property (p_ext)
        else $error("event counter moved without an edge");

    sequence s_fall;
        evtSync_r[1] ##1 !evtSync_r[1];
    endsequence

    property p_edge;
        s_fall |-> evtFall ##1 !evtFall;
    endproperty
    a_edge: assert property (p_edge)
        else $error("falling edge not a single pulse");

    property p_pin;
        pwmEn |-> pwmPinOe && (pwmPinOut == pwm_r);
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin not driven by PWM");

    property p_duty;
        countEn && dutyAbove && !ovfEvent && !enRise
            && (count_r == duty_r) |=> !pwm_r;
    endproperty
    a_duty: assert property (p_duty)
        else $error("PWM did not drop at duty match");

    property p_start;
        countEn && dutyAbove && ovfEvent |=> pwm_r;
    endproperty
    a_start: assert property (p_start)
        else $error("PWM cycle did not start high");

    property p_low;
        countEn && !dutyAbove |=> !pwm_r;
    endproperty
    a_low: assert property (p_low)
        else $error("PWM high though duty not above reload");

endmodule
`default_nettype wire

/* File: bench/tb_timer8_event_pwm_autoreload.sv */
// Purpose: Self-checking bench for the 8-bit timer with reload and PWM.
// Assumes: Register port reads answer one cycle after the read strobe.
// Notes: Ticks alternate sources so that the unselected one is exercised.
`timescale 1ns/1ps
`default_nettype none
module tb_timer8_event_pwm_autoreload
    import tmr_pkg::*;
;
    localparam logic [7:0] EN = 8'(1 << MODE_EN_BIT);
    localparam logic [7:0] EXT = 8'(1 << MODE_EXT_BIT);
    localparam logic [7:0] HSEL = 8'(1 << MODE_INT_BIT);
    localparam logic [7:0] PWM = 8'(1 << MODE_PWM_BIT);
    localparam int LIMIT = 12000;

    logic clk;
    logic reset;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic regWrite;
    logic regRead;
    logic [7:0] regRdData;
    logic cpuTick;
    logic hoscTick;
    logic eventPinIn;
    logic gpioOut;
    logic gpioOe;
    logic pwmPinOut;
    logic pwmPinOe;
    logic overflowIrq;
    logic wakeupReq;
    logic [7:0] rdv;
    int miscompares;
    int checked;
    int cycles;

    tmr_timer8 DUT (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .cpuTick(cpuTick), .hoscTick(hoscTick),
        .eventPinIn(eventPinIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .pwmPinOut(pwmPinOut), .pwmPinOe(pwmPinOe),
        .overflowIrq(overflowIrq), .wakeupReq(wakeupReq)
    );

    // ****************************************
    // Clock, timeout and closing
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // Read data stand only in the cycle after the read edge.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        rdv = regRdData;
    endtask

    // One tick of the chosen source, then one of the other source.
    task automatic tick(input logic h);
        @(posedge clk);
        cpuTick <= !h;
        hoscTick <= h;
        @(posedge clk);
        cpuTick <= h;
        hoscTick <= !h;
        @(posedge clk);
        cpuTick <= 1'b0;
        hoscTick <= 1'b0;
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(TMR_MODE_ADDR);
        chk(rdv, TMR_RST_VAL);
        rd(TMR_COUNT_ADDR);
        chk(rdv, TMR_RST_VAL);
        rd(TMR_DUTY_ADDR);
        chk(rdv, TMR_RST_VAL);
        wr(TMR_RELOAD_ADDR, 8'h5A);
        rd(TMR_RELOAD_ADDR);
        chk(rdv, 8'h00);
        wr(8'hC0, 8'hA5);
        rd(8'hC0);
        chk(rdv, 8'h00);
        wr(TMR_MODE_ADDR, 8'hFF);
        rd(TMR_MODE_ADDR);
        chk(rdv, MODE_RW_MASK);
        wr(TMR_MODE_ADDR, 8'h00);
        #1;
        chk({7'h00, overflowIrq}, 8'h00);
    endtask

    task automatic t_overflow();
        wr(TMR_COUNT_ADDR, 8'hFE);
        wr(TMR_RELOAD_ADDR, 8'hFE);
        wr(TMR_STAT_ADDR, 8'h02);
        wr(TMR_MODE_ADDR, EN | 8'h70);
        wr(TMR_RELOAD_ADDR, 8'h20);
        tick(1'b0);
        rd(TMR_COUNT_ADDR);
        chk(rdv, 8'hFF);
        chk({7'h00, overflowIrq}, 8'h00);
        tick(1'b0);
        rd(TMR_COUNT_ADDR);
        chk(rdv, 8'h20);
        chk({7'h00, overflowIrq}, 8'h01);
        wr(TMR_MODE_ADDR, 8'h70);
        tick(1'b0);
        rd(TMR_COUNT_ADDR);
        chk(rdv, 8'h20);
        rd(TMR_STAT_ADDR);
        chk(rdv, 8'h03);
        wr(TMR_STAT_ADDR, 8'h01);
        #1;
        chk({7'h00, overflowIrq}, 8'h00);
        wr(TMR_STAT_ADDR, 8'h02);
        rd(TMR_STAT_ADDR);
        chk(rdv, 8'h02);
        chk({7'h00, wakeupReq}, 8'h00);
    endtask

    // A whole number of prescaler periods gives exactly two counts.
    task automatic t_prescale();
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 8; c++) begin
                wr(TMR_MODE_ADDR, 8'h00);
                wr(TMR_COUNT_ADDR, 8'h00);
                wr(TMR_RELOAD_ADDR, 8'h00);
                wr(TMR_MODE_ADDR, EN | 8'(c << MODE_RATE_LSB) |
                    (s != 0 ? HSEL : 8'h00));
                for (int i = 0; i < (2 << (7 - c)); i++) begin
                    tick(s != 0);
                end
                rd(TMR_COUNT_ADDR);
                chk(rdv, 8'h02);
            end
        end
    endtask

    task automatic t_event();
        wr(TMR_MODE_ADDR, 8'h00);
        wr(TMR_COUNT_ADDR, 8'hFE);
        wr(TMR_RELOAD_ADDR, 8'hFE);
        wr(TMR_MODE_ADDR, EN | EXT);
        wr(TMR_RELOAD_ADDR, 8'h40);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            eventPinIn <= 1'b0;
            tick(1'b0);
            tick(1'b1);
            @(posedge clk);
            eventPinIn <= 1'b1;
            tick(1'b0);
            tick(1'b1);
        end
        rd(TMR_COUNT_ADDR);
        chk(rdv, 8'h41);
        rd(TMR_STAT_ADDR);
        chk(rdv, 8'h03);
    endtask

    task automatic t_pwm();
        logic [7:0] c;
        wr(TMR_MODE_ADDR, 8'h00);
        wr(TMR_COUNT_ADDR, 8'hF0);
        wr(TMR_RELOAD_ADDR, 8'hF0);
        wr(TMR_DUTY_ADDR, 8'hF4);
        wr(TMR_MODE_ADDR, EN | 8'h70 | PWM);
        @(posedge clk);
        #1;
        chk({7'h00, pwmPinOut}, 8'h01);
        chk({7'h00, pwmPinOe}, 8'h01);
        c = 8'hF0;
        for (int i = 0; i < 16; i++) begin
            tick(1'b0);
            c = (c == 8'hFF) ? 8'hF0 : c + 8'h01;
            chk({7'h00, pwmPinOut}, {7'h00, c < 8'hF4});
        end
        for (int g = 0; g < 4; g++) begin
            wr(TMR_MODE_ADDR, EN | 8'h70);
            gpioOut <= g[0];
            gpioOe <= g[1];
            @(posedge clk);
            #1;
            chk({6'h00, pwmPinOe, pwmPinOut}, 8'(g));
        end
        wr(TMR_DUTY_ADDR, 8'hF0);
        wr(TMR_MODE_ADDR, EN | 8'h70 | PWM);
        for (int i = 0; i < 17; i++) begin
            tick(1'b0);
            chk({7'h00, pwmPinOut}, 8'h00);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        miscompares = 0;
        checked = 0;
        cycles = 0;
        reset = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        cpuTick = 1'b0;
        hoscTick = 1'b0;
        eventPinIn = 1'b1;
        gpioOut = 1'b0;
        gpioOe = 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_overflow();
        t_prescale();
        t_event();
        t_pwm();
        chk({7'h00, wakeupReq}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
